// File: dcca_checker.sv
/*
  Port-level checker for the dual capture/compare arrays.
  Assumes binding to dcca_top and one clock domain on CORE_CLK.
*/
`timescale 1ns/10ps
`default_nettype none
module dcca_checker
    import dcca_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic GP_MODULE2_UPPER_TIMER_OVF,
    input wire logic ARRAY_A_COUNT_IN,
    input wire logic ARRAY_B_COUNT_IN,
    input wire logic [NUM_PIN-1:0] CC_IN,
    input wire logic [NUM_PIN-1:0] CC_OUT,
    input wire logic [NUM_PIN-1:0] CC_OE,
    input wire logic IRQ
);
    logic wr_done;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    // ==========================================================
    // Bus answer timing
    assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
    chk_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready missing one cycle after access");
    chk_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    chk_ready_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside an access phase");
    chk_slverr_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error response without ready or with data");
    chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside the ready cycle");
    // ==========================================================
    // Outputs after reset and their causes
    chk_reset_quiet: assert property ($fell(SRST) |-> !IRQ && CC_OUT == '0 && CC_OE == '0)
        else $error("outputs not cleared by reset");
    // Interrupt drops only through a register write
    chk_irq_fall: assert property ($fell(IRQ) && !$past(SRST) |-> $past(wr_done))
        else $error("interrupt fell without a write");
    // Undriven pins keep their level, e.g. after a single event
    chk_pin_hold: assert property (!$past(SRST) && !$past(wr_done) |->
        ((CC_OUT ^ $past(CC_OUT)) & ~CC_OE & ~$past(CC_OE)) == '0)
        else $error("pin moved while not an output");
endmodule : dcca_checker
`default_nettype wire

// File: dcca_pins.sv
/*
  Far-side model: capture pins, count pins and the overflow source.
  Assumes requests from the bench one cycle wide, set after an edge.
*/
`timescale 1ns/10ps
`default_nettype none
module dcca_pins
    import dcca_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [NUM_PIN-1:0] flip,
    input wire logic [2:0] req,
    output logic [NUM_PIN-1:0] cc_in,
    output logic ovf,
    output logic cnt_a,
    output logic cnt_b
);
    // Levels move just after an edge, so the design sees clean edges
    always_ff @(posedge clk)
    begin
        cc_in <= srst ? '0 : cc_in ^ flip;
        {cnt_b, cnt_a, ovf} <= srst ? 3'h0 : req;
    end
endmodule : dcca_pins
`default_nettype wire

// File: dcca_pkg.sv
/*
  Constants, field layout, register map and types of the dual
  capture/compare arrays. Assumes a 12-bit APB byte address.
*/
`default_nettype none
package dcca_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_CH = 32;
    localparam int NUM_TMR = 4;
    localparam int NUM_PIN = 28;
    localparam int ARRAY_CH = 16;
    localparam int HALF_CH = 8;
    localparam int TDW = 16;
    localparam int PRESC_W = 10;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] ADDR_GLOBAL_CTRL = 12'h000;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h004;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h008;
    localparam logic [7:0] PAGE_TMR_CTRL = 8'h01;
    localparam logic [7:0] PAGE_TMR_COUNT = 8'h02;
    localparam logic [7:0] PAGE_TMR_RELOAD = 8'h03;
    localparam logic [4:0] BLK_CH_CTRL = 5'h01;
    localparam logic [4:0] BLK_CH_VALUE = 5'h02;
    // ==========================================================
    // Field positions
    localparam int GC_STAGGER = 0;
    localparam int TC_RUN = 0;
    localparam int TC_PRESC_LSB = 1;
    localparam int TC_SRC_LSB = 4;
    localparam int TC_W = 6;
    localparam int CC_TSEL = 0;
    localparam int CC_FN_LSB = 1;
    localparam int CC_EDGE_LSB = 4;
    localparam int CC_DOUBLE = 6;
    localparam int CC_SINGLE = 7;
    localparam int CC_W = 8;
    localparam logic [3:0] STAGGER_SHIFT = 4'h3;
    // ==========================================================
    // Reset values
    localparam logic [TC_W-1:0] TCTRL_RESET = 6'h00;
    localparam logic [CC_W-1:0] CCTRL_RESET = 8'h00;
    localparam logic [TDW-1:0] TIMER_MAX = 16'hffff;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        FN_OFF = 3'h0, FN_CAPTURE = 3'h1, FN_CMP0 = 3'h2,
        FN_CMP1 = 3'h3, FN_CMP2 = 3'h4, FN_CMP3 = 3'h5
    } dcca_fn_t;
    typedef enum logic [1:0] {
        SRC_PRESC = 2'h0, SRC_GP_OVF = 2'h1, SRC_EXT = 2'h2
    } dcca_src_t;
    typedef enum logic [3:0] {
        RG_NONE, RG_GLOBAL, RG_STATUS, RG_MASK, RG_TCTRL,
        RG_TCNT, RG_TRELOAD, RG_CCTRL, RG_CVAL
    } dcca_region_t;

    // Address to register group
    function automatic dcca_region_t dcca_region(input logic [11:0] a);
        dcca_region_t r;
        r = RG_NONE;
        if (a[1:0] != 2'h0)
            r = RG_NONE;
        else if (a == ADDR_GLOBAL_CTRL)
            r = RG_GLOBAL;
        else if (a == ADDR_IRQ_STATUS)
            r = RG_STATUS;
        else if (a == ADDR_IRQ_MASK)
            r = RG_MASK;
        else if (a[11:4] == PAGE_TMR_CTRL)
            r = RG_TCTRL;
        else if (a[11:4] == PAGE_TMR_COUNT)
            r = RG_TCNT;
        else if (a[11:4] == PAGE_TMR_RELOAD)
            r = RG_TRELOAD;
        else if (a[11:7] == BLK_CH_CTRL)
            r = RG_CCTRL;
        else if (a[11:7] == BLK_CH_VALUE)
            r = RG_CVAL;
        return r;
    endfunction : dcca_region
endpackage : dcca_pkg
`default_nettype wire

// File: dcca_top.sv
/*
  Dual capture/compare arrays: four reloadable timers, 32 channels,
  APB register slave and one level interrupt.
  Assumes all inputs synchronous to CORE_CLK and an APB3 master.
*/
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - 32 channels, one-cycle or eight-cycle resolution
// - four 16-bit reloadable timers, two per array
// - timer clock from prescaler or GP overflow
// - first timer of array counts external pin
// - 16 channels per array, timer/function selectable
// - array B has twelve pin channels
// - mode 0 interrupts every match, pin untouched
// - mode 1 toggles pin every match
// - mode 2 interrupts once per period
// - mode 3 sets on match, clears on overflow
// - double mode: two channels toggle one pin
// - single-event option stops after one event
// - capture latches allocated timer on pin edge
// - capture raises channel-specific interrupt request
// - capture edge rising, falling, or both
// - compare continuously, act on equality
module dcca_top
    import dcca_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic GP_MODULE2_UPPER_TIMER_OVF,
    input wire logic ARRAY_A_COUNT_IN,
    input wire logic ARRAY_B_COUNT_IN,
    input wire logic [NUM_PIN-1:0] CC_IN,
    output logic [NUM_PIN-1:0] CC_OUT,
    output logic [NUM_PIN-1:0] CC_OE,
    output logic IRQ
);
    // ==========================================================
    // State declarations
    logic stagger, next_stagger;
    logic [NUM_CH-1:0] irq_status, next_irq_status;
    logic [NUM_CH-1:0] irq_mask, next_irq_mask;
    logic next_irq;
    logic [PRESC_W-1:0] presc, next_presc;
    logic [1:0] ext_prev, next_ext_prev;
    logic [NUM_PIN-1:0] in_prev, next_in_prev;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic [TC_W-1:0] tctrl [NUM_TMR];
    logic [TDW-1:0] tcnt [NUM_TMR];
    logic [TDW-1:0] treload [NUM_TMR];
    logic [NUM_TMR-1:0] tupd, tovf;
    logic [CC_W-1:0] cctrl [NUM_CH];
    logic [TDW-1:0] cval [NUM_CH];
    logic [NUM_CH-1:0] armed;
    logic [NUM_CH-1:0] ch_ev, ch_tog, ch_set, ch_clr;
    logic [NUM_PIN-1:0] next_cc_out, next_cc_oe;
    logic [1:0] ext_edge;
    dcca_region_t rg;
    logic wr_en;

    // ==========================================================
    // Function decode shared by channels and pin drivers
    // Codes 6 and 7 are off: a plain lower bound would let them drive a pin
    function automatic logic cmp_fn(input logic [2:0] f);
        return (f >= FN_CMP0) && (f <= FN_CMP3);
    endfunction : cmp_fn

    // ==========================================================
    // APB decode
    // Writes land on the edge where PREADY is sampled high
    assign rg = dcca_region(PADDR);
    assign wr_en = PSEL & PENABLE & PWRITE & PREADY;
    // One wait state: data and error are registered
    always_comb
    begin
        next_pready = PSEL & PENABLE & ~PREADY;
        next_pslverr = next_pready & (rg == RG_NONE);
        next_prdata = 32'h0;
        if (next_pready)
        begin
            case (rg)
                RG_GLOBAL: next_prdata = {31'h0, stagger};
                RG_STATUS: next_prdata = irq_status;
                RG_MASK: next_prdata = irq_mask;
                RG_TCTRL: next_prdata = {26'h0, tctrl[PADDR[3:2]]};
                RG_TCNT: next_prdata = {16'h0, tcnt[PADDR[3:2]]};
                RG_TRELOAD: next_prdata = {16'h0, treload[PADDR[3:2]]};
                RG_CCTRL: next_prdata = {24'h0, cctrl[PADDR[6:2]]};
                RG_CVAL: next_prdata = {16'h0, cval[PADDR[6:2]]};
                default: next_prdata = 32'h0;
            endcase
        end
    end

    // ==========================================================
    // Global, interrupt and prescaler state
    always_comb
    begin
        next_stagger = stagger;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status | ch_ev;
        if (wr_en && rg == RG_GLOBAL)
            next_stagger = PWDATA[GC_STAGGER];
        if (wr_en && rg == RG_MASK)
            next_irq_mask = PWDATA;
        // Set wins over a write-one clear in the same cycle
        if (wr_en && rg == RG_STATUS)
            next_irq_status = (irq_status & ~PWDATA) | ch_ev;
        next_irq = |(next_irq_status & next_irq_mask);
        next_presc = PRESC_W'(presc + 1'b1);
        next_ext_prev = {ARRAY_B_COUNT_IN, ARRAY_A_COUNT_IN};
        next_in_prev = CC_IN;
    end

    // Registers of the shared group
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            stagger <= 1'b0;
            irq_status <= '0;
            irq_mask <= '0;
            IRQ <= 1'b0;
            presc <= '0;
            ext_prev <= 2'h0;
            in_prev <= '0;
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            CC_OUT <= '0;
            CC_OE <= '0;
        end
        else
        begin
            stagger <= next_stagger;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            IRQ <= next_irq;
            presc <= next_presc;
            ext_prev <= next_ext_prev;
            in_prev <= next_in_prev;
            PRDATA <= next_prdata;
            PREADY <= next_pready;
            PSLVERR <= next_pslverr;
            CC_OUT <= next_cc_out;
            CC_OE <= next_cc_oe;
        end
    end

    // Rising edges of the external count inputs
    assign ext_edge = {ARRAY_B_COUNT_IN, ARRAY_A_COUNT_IN} & ~ext_prev;

    // ==========================================================
    // Timers: index 0,1 array A, 2,3 array B
    for (genvar t = 0; t < NUM_TMR; t++)
    begin : g_tmr
        logic [TC_W-1:0] next_tctrl;
        logic [TDW-1:0] next_tcnt, next_treload;
        logic next_tupd, next_tovf, tick;
        logic [3:0] eff;
        logic [15:0] pmask;
        dcca_src_t src;
        assign src = dcca_src_t'(tctrl[t][TC_SRC_LSB+:2]);
        // Staggered mode coarsens resolution to eight cycles
        assign eff = {1'b0, tctrl[t][TC_PRESC_LSB+:3]} + (stagger ? STAGGER_SHIFT : 4'h0);
        assign pmask = 16'((16'h1 << eff) - 16'h1);

        // Count source selection and reload
        always_comb
        begin
            case (src)
                SRC_PRESC: tick = (presc & pmask[PRESC_W-1:0]) == pmask[PRESC_W-1:0];
                SRC_GP_OVF: tick = GP_MODULE2_UPPER_TIMER_OVF;
                SRC_EXT: tick = ((t % 2) == 0) ? ext_edge[t/2] : 1'b0;
                default: tick = 1'b0;
            endcase
            tick = tick & tctrl[t][TC_RUN];
            next_tctrl = tctrl[t];
            next_treload = treload[t];
            next_tcnt = tcnt[t];
            next_tupd = 1'b0;
            next_tovf = 1'b0;
            if (tick)
            begin
                next_tupd = 1'b1;
                if (tcnt[t] == TIMER_MAX)
                begin
                    next_tcnt = treload[t];
                    next_tovf = 1'b1;
                end
                else
                    next_tcnt = TDW'(tcnt[t] + 1'b1);
            end
            // Software write to the count overrides a tick
            if (wr_en && rg == RG_TCNT && PADDR[3:2] == 2'(t))
            begin
                next_tcnt = PWDATA[TDW-1:0];
                next_tupd = 1'b0;
                next_tovf = 1'b0;
            end
            if (wr_en && rg == RG_TCTRL && PADDR[3:2] == 2'(t))
                next_tctrl = PWDATA[TC_W-1:0];
            if (wr_en && rg == RG_TRELOAD && PADDR[3:2] == 2'(t))
                next_treload = PWDATA[TDW-1:0];
        end

        // Timer registers
        always_ff @(posedge CORE_CLK)
        begin
            if (SRST)
            begin
                tctrl[t] <= TCTRL_RESET;
                tcnt[t] <= '0;
                treload[t] <= '0;
                tupd[t] <= 1'b0;
                tovf[t] <= 1'b0;
            end
            else
            begin
                tctrl[t] <= next_tctrl;
                tcnt[t] <= next_tcnt;
                treload[t] <= next_treload;
                tupd[t] <= next_tupd;
                tovf[t] <= next_tovf;
            end
        end
    end

    // ==========================================================
    // Channels: 0..15 array A, 16..31 array B
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        logic [CC_W-1:0] next_cctrl;
        logic [TDW-1:0] next_cval;
        logic next_armed, match, rise, fall, ev, is_cmp;
        logic [1:0] tsel;
        dcca_fn_t fn;
        assign tsel = {1'(c / ARRAY_CH), cctrl[c][CC_TSEL]};
        assign fn = dcca_fn_t'(cctrl[c][CC_FN_LSB+:3]);
        // Match only when the timer just moved, so a stopped timer gives one event
        assign match = tupd[tsel] && (cval[c] == tcnt[tsel]);
        assign is_cmp = cmp_fn(fn);
        // Channels 28..31 have no pin and never capture
        if (c < NUM_PIN)
        begin : g_edge
            assign rise = CC_IN[c] & ~in_prev[c];
            assign fall = ~CC_IN[c] & in_prev[c];
        end
        else
        begin : g_noedge
            assign rise = 1'b0;
            assign fall = 1'b0;
        end

        // Event detection and channel state
        always_comb
        begin
            next_cctrl = cctrl[c];
            next_cval = cval[c];
            next_armed = armed[c];
            if (wr_en && rg == RG_CCTRL && PADDR[6:2] == 5'(c))
            begin
                next_cctrl = PWDATA[CC_W-1:0];
                next_armed = 1'b1;
            end
            if (wr_en && rg == RG_CVAL && PADDR[6:2] == 5'(c))
                next_cval = PWDATA[TDW-1:0];
            case (fn)
                FN_CAPTURE: ev = (cctrl[c][CC_EDGE_LSB] & rise) | (cctrl[c][CC_EDGE_LSB+1] & fall);
                FN_CMP0: ev = match;
                FN_CMP1: ev = match;
                FN_CMP2: ev = match & armed[c];
                FN_CMP3: ev = match & armed[c];
                default: ev = 1'b0;
            endcase
            // Capture beats a software write of the same value register
            if (fn == FN_CAPTURE && ev)
                next_cval = tcnt[tsel];
            if (ev && (fn == FN_CMP2 || fn == FN_CMP3))
                next_armed = 1'b0;
            // A new period starts armed even if it also matched
            if (tovf[tsel])
                next_armed = 1'b1;
            // Single event: function falls back to off after one
            if (ev && cctrl[c][CC_SINGLE])
                next_cctrl[CC_FN_LSB+:3] = FN_OFF;
        end

        // Pin requests of this channel
        assign ch_ev[c] = ev;
        assign ch_tog[c] = ev && (fn == FN_CMP1 || (is_cmp && cctrl[c][CC_DOUBLE]));
        assign ch_set[c] = ev && fn == FN_CMP3 && !cctrl[c][CC_DOUBLE];
        assign ch_clr[c] = fn == FN_CMP3 && tovf[tsel] && !cctrl[c][CC_DOUBLE];

        // Channel registers
        always_ff @(posedge CORE_CLK)
        begin
            if (SRST)
            begin
                cctrl[c] <= CCTRL_RESET;
                cval[c] <= '0;
                armed[c] <= 1'b1;
            end
            else
            begin
                cctrl[c] <= next_cctrl;
                cval[c] <= next_cval;
                armed[c] <= next_armed;
            end
        end
    end

    // ==========================================================
    // Pin drivers; upper-half double channels act on the lower pin
    for (genvar p = 0; p < NUM_PIN; p++)
    begin : g_pin
        localparam int K = p % ARRAY_CH;
        logic own, part_tog, part_cmp, lvl;
        dcca_fn_t pfn;
        assign pfn = dcca_fn_t'(cctrl[p][CC_FN_LSB+:3]);
        assign own = !((K >= HALF_CH) && cctrl[p][CC_DOUBLE]);
        if (K < HALF_CH)
        begin : g_pair
            assign part_tog = cctrl[p+HALF_CH][CC_DOUBLE] & ch_tog[p+HALF_CH];
            assign part_cmp = cctrl[p+HALF_CH][CC_DOUBLE] && cmp_fn(cctrl[p+HALF_CH][CC_FN_LSB+:3]);
        end
        else
        begin : g_nopair
            assign part_tog = 1'b0;
            assign part_cmp = 1'b0;
        end
        // Mode 0 and 2 raise no pin request outside double mode, so the pin holds
        always_comb
        begin
            lvl = CC_OUT[p];
            if (own && ch_set[p])
                lvl = 1'b1;
            else if (own && ch_clr[p])
                lvl = 1'b0;
            next_cc_out[p] = lvl ^ (own & ch_tog[p]) ^ part_tog;
            next_cc_oe[p] = (own && cmp_fn(pfn)) || part_cmp;
        end
    end
endmodule : dcca_top
`default_nettype wire

// File: dual_capture_compare_arrays_bench.sv
/*
  Self-checking bench: APB tasks, compare, capture and timer tests.
  Assumes dcca_top, dcca_pins and dcca_checker compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module dual_capture_compare_arrays_bench;
    import dcca_pkg::*;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, irq, ovf, cnt_a, cnt_b, err;
    logic [2:0] req = 3'h0;
    logic [NUM_PIN-1:0] flip = '0, cc_in, cc_out, cc_oe;
    int n_errors = 0, n_checks = 0, cycles = 0;
    // ==========================================================
    // Clock, design and far side
    initial
    begin
        forever #20 clk = ~clk;
    end
    dcca_top dcca_top_i (.CORE_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .GP_MODULE2_UPPER_TIMER_OVF(ovf), .ARRAY_A_COUNT_IN(cnt_a),
        .ARRAY_B_COUNT_IN(cnt_b), .CC_IN(cc_in), .CC_OUT(cc_out), .CC_OE(cc_oe), .IRQ(irq));
    dcca_pins dcca_pins_i (.clk(clk), .srst(srst), .flip(flip), .req(req), .cc_in(cc_in),
        .ovf(ovf), .cnt_a(cnt_a), .cnt_b(cnt_b));
    // ==========================================================
    // Tasks
    task final_report;
        $display("Checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // One transfer; request held until ready is seen at an edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16)
            cmp("pready", 32'h1, 32'h0);
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        cmp(what, exp, q);
    endtask : rd
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // Far-side requests last exactly one cycle
    task pulse(input logic [NUM_PIN-1:0] f, input logic [2:0] r);
        flip <= f;
        req <= r;
        @(posedge clk);
        flip <= '0;
        req <= 3'h0;
    endtask : pulse
    // ==========================================================
    // Hang guard: the whole run needs well under 1500 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            final_report();
        end
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        tick(12);
        srst <= 1'b0;
        rd(ADDR_GLOBAL_CTRL, 32'h0, "global ctrl");
        rd(12'h030, 32'h0, "reload 0");
        apb(1'b0, 12'h200, 32'h0);
        cmp("slverr", 32'h1, err);
        cmp("unmapped data", 32'h0, q);
        $display("Test registers done");
        // Channels 0..2 on timer 0: modes 0, 1, 3; only channel 0 unmasked
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(12'h100, 32'hfff8);
        wr(12'h104, 32'hfff4);
        wr(12'h108, 32'hfff6);
        wr(12'h080, 32'h04);
        wr(12'h084, 32'h06);
        wr(12'h088, 32'h0a);
        wr(12'h020, 32'hfff0);
        wr(12'h030, 32'hff00);
        wr(12'h010, 32'h01);
        tick(6);
        cmp("irq masked", 32'h0, irq);
        tick(6);
        cmp("irq mode0", 32'h1, irq);
        cmp("pin toggle", 32'h1, cc_out[1]);
        cmp("oe toggle", 32'h1, cc_oe[1]);
        cmp("pin set", 32'h1, cc_out[2]);
        tick(10);
        cmp("pin cleared", 32'h0, cc_out[2]);
        tick(236);
        cmp("pin held", 32'h1, cc_out[1]);
        cmp("no early set", 32'h0, cc_out[2]);
        tick(12);
        cmp("pin again", 32'h0, cc_out[1]);
        cmp("set rearmed", 32'h1, cc_out[2]);
        cmp("pin mode0", 32'h0, cc_out[0]);
        rd(ADDR_IRQ_STATUS, 32'h7, "status cmp");
        wr(ADDR_IRQ_STATUS, 32'h1);
        tick(1);
        cmp("irq cleared", 32'h0, irq);
        wr(12'h010, 32'h0);
        $display("Test compare done");
        // Capture on channel 4 from stopped timer 1, rising edge only
        wr(ADDR_IRQ_STATUS, 32'hffffffff);
        wr(12'h024, 32'h1234);
        wr(12'h090, 32'h13);
        pulse(28'h10, 3'h0);
        tick(3);
        rd(12'h110, 32'h1234, "capture rise");
        wr(12'h024, 32'h5678);
        pulse(28'h10, 3'h0);
        tick(3);
        rd(12'h110, 32'h1234, "falling ignored");
        rd(ADDR_IRQ_STATUS, 32'h10, "status capture");
        $display("Test capture done");
        // External count and overflow source
        wr(12'h030, 32'habcd);
        wr(12'h020, 32'hffff);
        wr(12'h010, 32'h21);
        pulse('0, 3'h2);
        tick(3);
        rd(12'h020, 32'habcd, "ext count reload");
        wr(12'h014, 32'h11);
        pulse('0, 3'h1);
        tick(3);
        rd(12'h024, 32'h5679, "gp overflow tick");
        $display("Test timers done");
        // Array B, timer 2: channels 16 and 24 double toggle pin 16, channel 17 mode 2 single
        wr(12'h0c0, 32'h46);
        wr(12'h0e0, 32'h46);
        wr(12'h0c4, 32'h88);
        wr(12'h140, 32'h10);
        wr(12'h160, 32'h20);
        wr(12'h144, 32'h18);
        wr(ADDR_IRQ_STATUS, 32'hffffffff);
        wr(12'h028, 32'h0);
        wr(12'h018, 32'h01);
        tick(20);
        cmp("double first", 32'h1, cc_out[16]);
        tick(20);
        cmp("double second", 32'h0, cc_out[16]);
        cmp("double oe", 32'h1, cc_oe[16]);
        cmp("partner pin idle", 32'h0, cc_oe[24]);
        rd(ADDR_IRQ_STATUS, 32'h01030000, "status array b");
        rd(12'h0c4, 32'h80, "single event off");
        $display("Test double done");
        final_report();
    end
endmodule : dual_capture_compare_arrays_bench
bind dcca_top dcca_checker dcca_checker_i (.CORE_CLK(CORE_CLK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .GP_MODULE2_UPPER_TIMER_OVF(GP_MODULE2_UPPER_TIMER_OVF),
    .ARRAY_A_COUNT_IN(ARRAY_A_COUNT_IN), .ARRAY_B_COUNT_IN(ARRAY_B_COUNT_IN), .CC_IN(CC_IN),
    .CC_OUT(CC_OUT), .CC_OE(CC_OE), .IRQ(IRQ));
`default_nettype wire
